// ==== rtl/irq_front.sv ====
// external interrupt request front end with avalon-mm register slave
`timescale 1ns/1ps
module irq_front (
   input  wire logic                                 i_ref_clk,
   input  wire logic                                 i_rst_n,
   input  wire logic [irq_front_pkg::ADDR_W-1:0]     i_avs_address,
   input  wire logic                                 i_avs_read,
   input  wire logic                                 i_avs_write,
   input  wire logic [irq_front_pkg::DATA_W-1:0]     i_avs_writedata,
   input  wire logic [irq_front_pkg::BE_W-1:0]       i_avs_byteenable,
   output logic      [irq_front_pkg::DATA_W-1:0]     o_avs_readdata,
   output logic                                      o_avs_waitrequest,
   input  wire logic                                 i_nmi_pin,
   input  wire logic [irq_front_pkg::EXT_CH-1:0]     i_ext_request_pin,
   input  wire logic [irq_front_pkg::INT_SRC-1:0]    i_int_flag,
   input  wire logic [irq_front_pkg::INT_SRC-1:0]    i_int_enable,
   input  wire logic                                 i_ack_valid,
   input  wire logic [irq_front_pkg::VEC_W-1:0]      i_ack_vector,
   input  wire logic                                 i_xfer_start,
   input  wire logic [irq_front_pkg::CH_W-1:0]       i_xfer_channel,
   input  wire logic                                 i_xfer_int_select,
   output logic                                      o_nmi_req,
   output logic      [irq_front_pkg::EXT_CH-1:0]     o_ext_req,
   output logic      [irq_front_pkg::EXT_CH-1:0]     o_ext_level,
   output logic      [irq_front_pkg::EXT_CH-1:0]     o_xfer_req,
   output logic      [irq_front_pkg::INT_SRC-1:0]    o_int_req,
   output logic      [irq_front_pkg::INT_SRC-1:0]    o_int_level,
   output logic                                      o_wake
);
   import irq_front_pkg::*;

   typedef enum logic {BUS_IDLE, BUS_ACK} bus_t;

   typedef struct packed {
      bus_t                bus;
      logic                wait_r;
      logic [DATA_W-1:0]   rdata;
      logic                nmi_sel;
      logic [2*EXT_CH-1:0] sense;
      logic [EXT_CH-1:0]   en;
      logic [EXT_CH-1:0]   flag;
      logic                nmi_flag;
      logic [EXT_CH-1:0]   lvl_ext;
      logic [INT_SRC-1:0]  lvl_int;
      logic [EXT_CH-1:0]   s1;
      logic [EXT_CH-1:0]   s2;
      logic [EXT_CH-1:0]   s3;
      logic [EXT_CH-1:0]   filt;
      logic                n1;
      logic                n2;
      logic                n3;
      logic                nfilt;
      logic                nmi_req;
      logic [EXT_CH-1:0]   ext_req;
      logic [EXT_CH-1:0]   ext_level;
      logic [EXT_CH-1:0]   xfer_req;
      logic [INT_SRC-1:0]  int_req;
      logic                wake;
   } state_t;

   state_t              s_r;
   state_t              s_nxt;
   logic [EXT_CH-1:0]   set_vec;
   logic [EXT_CH-1:0]   ack_clr;
   logic [EXT_CH-1:0]   xfer_clr;
   logic [EXT_CH-1:0]   lvl_map;
   logic [DATA_W-1:0]   be_mask;
   logic                nmi_agree;
   logic                nmi_edge;
   logic                req;
   logic                sw_status_wr;

   assign req = i_avs_read | i_avs_write;
   // write to the flag register taking effect this cycle
   assign sw_status_wr = (s_r.bus == BUS_ACK) & i_avs_write & (i_avs_address == OFF_STATUS);

   generate
      for (genvar i = 0; i < BE_W; i++) begin : g_be
         assign be_mask[8*i +: 8] = {8{i_avs_byteenable[i]}};
      end
      for (genvar i = 0; i < EXT_CH; i++) begin : g_ch
         logic       agree;
         logic       lvl;
         logic [1:0] mode;
         assign agree = s_r.s2[i] == s_r.s3[i];
         assign lvl   = s_r.s2[i];
         assign mode  = {s_r.sense[2*i+SENSE_B], s_r.sense[2*i+SENSE_A]};
         always_comb begin
            case (mode)
               MODE_LOW:  set_vec[i] = agree & ~lvl;
               MODE_FALL: set_vec[i] = agree & s_r.filt[i] & ~lvl;
               MODE_RISE: set_vec[i] = agree & ~s_r.filt[i] & lvl;
               MODE_BOTH: set_vec[i] = agree & (s_r.filt[i] ^ lvl);
               default:   set_vec[i] = 1'b0;
            endcase
         end
         // vector 16 + channel; low mode clears only with pin high
         assign ack_clr[i] = i_ack_valid
                             & (i_ack_vector == VEC_EXT_BASE + VEC_W'(i))
                             & ((mode != MODE_LOW) | s_r.filt[i]);
         assign xfer_clr[i] = i_xfer_start & ~i_xfer_int_select
                              & (i_xfer_channel == CH_W'(i));
         assign lvl_map[i] = s_r.lvl_ext[CH_LVL_IDX[i]];
      end
   endgenerate

   assign nmi_agree = s_r.n2 == s_r.n3;
   // selected edge of the non-maskable pin
   assign nmi_edge  = nmi_agree & (s_r.nfilt != s_r.n2) & (s_r.n2 == s_r.nmi_sel);

   always_comb begin
      s_nxt = s_r;
      // pins sampled by level, direction unused
      s_nxt.s1 = i_ext_request_pin;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.n1 = i_nmi_pin;
      s_nxt.n2 = s_r.n1;
      s_nxt.n3 = s_r.n2;
      for (int i = 0; i < EXT_CH; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.filt[i] = s_r.s2[i];
         end
      end
      if (nmi_agree) begin
         s_nxt.nfilt = s_r.n2;
      end
      // bus slave: one wait cycle, then the answer
      s_nxt.bus    = BUS_IDLE;
      s_nxt.wait_r = 1'b1;
      if (s_r.bus == BUS_IDLE && req) begin
         s_nxt.bus    = BUS_ACK;
         s_nxt.wait_r = 1'b0;
         case (i_avs_address)
            OFF_SYS:      s_nxt.rdata = DATA_W'(s_r.nmi_sel);
            OFF_SENSE:    s_nxt.rdata = DATA_W'(s_r.sense);
            OFF_ENABLE:   s_nxt.rdata = DATA_W'(s_r.en);
            OFF_STATUS:   s_nxt.rdata = DATA_W'(s_r.flag);
            OFF_LVL_EXT:  s_nxt.rdata = DATA_W'(s_r.lvl_ext);
            OFF_LVL_INT0: s_nxt.rdata = s_r.lvl_int[DATA_W-1:0];
            OFF_LVL_INT1: s_nxt.rdata = DATA_W'(s_r.lvl_int[INT_SRC-1:DATA_W]);
            default:      s_nxt.rdata = RD_ZERO;
         endcase
      end
      s_nxt.flag = s_r.flag & ~ack_clr & ~xfer_clr;
      if (s_r.bus == BUS_ACK && i_avs_write) begin
         case (i_avs_address)
            OFF_SYS: begin
               if (i_avs_byteenable[0]) begin
                  s_nxt.nmi_sel = i_avs_writedata[SYS_NMI_EDGE];
               end
            end
            OFF_SENSE: begin
               s_nxt.sense = (s_r.sense & ~be_mask[2*EXT_CH-1:0])
                             | (i_avs_writedata[2*EXT_CH-1:0] & be_mask[2*EXT_CH-1:0]);
            end
            OFF_ENABLE: begin
               if (i_avs_byteenable[0]) begin
                  s_nxt.en = i_avs_writedata[EXT_CH-1:0];
               end
            end
            OFF_STATUS: begin
               // write 0 clears, write 1 keeps
               if (i_avs_byteenable[0]) begin
                  s_nxt.flag = s_nxt.flag & i_avs_writedata[EXT_CH-1:0];
               end
            end
            OFF_LVL_EXT: begin
               if (i_avs_byteenable[0]) begin
                  s_nxt.lvl_ext = i_avs_writedata[EXT_CH-1:0];
               end
            end
            OFF_LVL_INT0: begin
               s_nxt.lvl_int[DATA_W-1:0] = (s_r.lvl_int[DATA_W-1:0] & ~be_mask)
                                           | (i_avs_writedata & be_mask);
            end
            OFF_LVL_INT1: begin
               if (i_avs_byteenable[0]) begin
                  s_nxt.lvl_int[INT_SRC-1:DATA_W] = i_avs_writedata[LVL_INT_HI_W-1:0];
               end
            end
            default: begin
               s_nxt.rdata = s_r.rdata;
            end
         endcase
      end
      // set regardless of enable, set wins over any clear
      s_nxt.flag = s_nxt.flag | set_vec;
      // acknowledge of vector 7 clears the non-maskable flag
      if (i_ack_valid && i_ack_vector == VEC_NMI) begin
         s_nxt.nmi_flag = 1'b0;
      end
      if (nmi_edge) begin
         s_nxt.nmi_flag = 1'b1;
      end
      // no mask on the non-maskable request
      s_nxt.nmi_req   = s_r.nmi_flag;
      s_nxt.ext_req   = s_r.flag & s_r.en;
      s_nxt.ext_level = lvl_map;
      // transfer request sees no CPU mask or control mode
      s_nxt.xfer_req  = s_r.flag & s_r.en;
      // internal sources forwarded on flag and enable
      s_nxt.int_req   = i_int_flag & i_int_enable;
      // wake only from non-maskable and channels 2..0
      s_nxt.wake      = s_r.nmi_flag | (|(s_r.flag & s_r.en & WAKE_MASK));
      if (!i_rst_n) begin
         s_nxt        = '0;
         s_nxt.bus    = BUS_IDLE;
         s_nxt.wait_r = 1'b1;
         s_nxt.s1     = '1;
         s_nxt.s2     = '1;
         s_nxt.s3     = '1;
         s_nxt.filt   = '1;
         s_nxt.n1     = 1'b1;
         s_nxt.n2     = 1'b1;
         s_nxt.n3     = 1'b1;
         s_nxt.nfilt  = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      s_r <= s_nxt;
   end

   assign o_avs_readdata    = s_r.rdata;
   assign o_avs_waitrequest = s_r.wait_r;
   assign o_nmi_req         = s_r.nmi_req;
   assign o_ext_req         = s_r.ext_req;
   assign o_ext_level       = s_r.ext_level;
   assign o_xfer_req        = s_r.xfer_req;
   assign o_int_req         = s_r.int_req;
   // internal levels straight from their register
   assign o_int_level       = s_r.lvl_int;
   assign o_wake            = s_r.wake;

   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   a_low_level_set: assert property (
      (g_ch[0].mode == MODE_LOW && g_ch[0].agree && !s_r.s2[0]) |=> s_r.flag[0])
      else $error("low level did not set flag");
   a_fall_edge_set: assert property (
      (g_ch[1].mode == MODE_FALL && s_r.filt[1] && s_r.s2[1] == s_r.s3[1]
       && !s_r.s2[1]) |=> s_r.flag[1])
      else $error("falling edge did not set flag");
   a_rise_edge_set: assert property (
      (g_ch[2].mode == MODE_RISE && $fell(s_r.s1[2]) ##1 !s_r.s1[2] ##1
       $rose(s_r.s1[2]) ##2 s_r.s2[2] == s_r.s3[2]) |=> s_r.flag[2])
      else $error("rising edge did not set flag");
   a_both_edge_set: assert property (
      (g_ch[3].mode == MODE_BOTH && g_ch[3].agree && s_r.filt[3] != s_r.s2[3])
      |=> s_r.flag[3])
      else $error("edge in both mode did not set flag");
   a_nmi_edge_sel: assert property (
      (s_r.nmi_sel == 1'b0 && nmi_agree && s_r.nfilt && !s_r.n2)
      |=> s_r.nmi_flag ##1 o_nmi_req)
      else $error("selected nmi edge not raised");
   a_wake_limited: assert property (
      (!s_r.nmi_flag && (s_r.flag & WAKE_MASK) == '0) |=> !o_wake)
      else $error("wake from a channel that cannot wake");
   a_enable_gate: assert property (
      (o_ext_req & ~$past(s_r.en)) == '0)
      else $error("disabled channel reached the CPU");
   a_flag_ignores_en: assert property (
      (s_r.en[0] == 1'b0 && set_vec[0]) |=> s_r.flag[0] ##1 !o_ext_req[0])
      else $error("flag not set with enable clear");
   a_ack_clears: assert property (
      (i_ack_valid && i_ack_vector == VEC_EXT_BASE && g_ch[0].mode != MODE_LOW
       && !set_vec[0]) |=> !s_r.flag[0])
      else $error("exception handling left edge flag set");
   a_xfer_clears: assert property (
      (i_xfer_start && !i_xfer_int_select && i_xfer_channel == '0 && !set_vec[0])
      |=> !s_r.flag[0])
      else $error("transfer start left flag set");
   a_int_forward: assert property (
      (i_int_flag[0] && i_int_enable[0]) |=> o_int_req[0])
      else $error("peripheral request not forwarded");
   a_bus_answer: assert property (
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one cycle after request");

   a_nmi_unmasked: assert property (
      s_r.nmi_flag |=> o_nmi_req)
      else $error("nmi request was masked");

   a_nmi_vec_clear: assert property (
      (i_ack_valid && i_ack_vector == VEC_NMI && !nmi_edge) |=> !s_r.nmi_flag)
      else $error("nmi flag kept after its exception");

   a_vec_top_clear: assert property (
      (i_ack_valid && i_ack_vector == VEC_EXT_TOP && g_ch[7].mode != MODE_LOW
       && !set_vec[7]) |=> !s_r.flag[7])
      else $error("channel 7 flag kept after its exception");

   a_vec_other_keep: assert property (
      (i_ack_valid && i_ack_vector == VEC_NMI && s_r.flag[0] && !i_xfer_start
       && !sw_status_wr) |=> s_r.flag[0])
      else $error("nmi exception cleared a channel flag");

   a_low_ack_keep: assert property (
      (i_ack_valid && i_ack_vector == VEC_EXT_BASE && g_ch[0].mode == MODE_LOW
       && !s_r.filt[0] && s_r.flag[0] && !i_xfer_start && !sw_status_wr)
      |=> s_r.flag[0])
      else $error("low level flag cleared while pin low");

   a_level_map: assert property (
      {o_ext_level[0], o_ext_level[3], o_ext_level[7]}
      == $past({s_r.lvl_ext[7], s_r.lvl_ext[5], s_r.lvl_ext[3]}))
      else $error("channel control level not mapped");

   a_sw_clear: assert property (
      (sw_status_wr && i_avs_byteenable[0] && !i_avs_writedata[1] && !set_vec[1])
      |=> !s_r.flag[1])
      else $error("software write of 0 left flag set");

   a_sw_keep: assert property (
      (sw_status_wr && i_avs_writedata[1] && s_r.flag[1] && !ack_clr[1]
       && !xfer_clr[1]) |=> s_r.flag[1])
      else $error("software write of 1 cleared flag");

   a_xfer_unmasked: assert property (
      (s_r.flag[5] && s_r.en[5]) |=> o_xfer_req[5])
      else $error("transfer request not raised");

   a_int_level_hi: assert property (
      (s_r.bus == BUS_ACK && i_avs_write && i_avs_address == OFF_LVL_INT1
       && i_avs_byteenable[0])
      |=> o_int_level[INT_SRC-1:DATA_W] == $past(i_avs_writedata[LVL_INT_HI_W-1:0]))
      else $error("internal control level not written");

   a_int_masked: assert property (
      !i_int_enable[INT_SRC-1] |=> !o_int_req[INT_SRC-1])
      else $error("disabled peripheral request forwarded");

   a_wake_nmi: assert property (
      s_r.nmi_flag |=> o_wake)
      else $error("nmi did not wake");

   c_low_level: cover property (g_ch[0].mode == MODE_LOW ##1 $rose(s_r.flag[0]));
   c_xfer_clear: cover property ($fell(o_xfer_req[5]));
   c_nmi_req:   cover property ($rose(o_nmi_req));
   c_sw_clear:  cover property ($fell(s_r.flag[0]) && !$past(i_ack_valid));
   c_wake:      cover property ($rose(o_wake));
endmodule : irq_front

// ==== inc/irq_front_pkg.sv ====
// constants for the external interrupt request front end
package irq_front_pkg;
   localparam int          EXT_CH       = 8;
   localparam int          INT_SRC      = 34;
   localparam int          ADDR_W       = 5;
   localparam int          DATA_W       = 32;
   localparam int          BE_W         = 4;
   localparam int          VEC_W        = 6;
   localparam int          CH_W         = 3;
   // register byte offsets
   localparam logic [4:0]  OFF_SYS      = 5'h00;
   localparam logic [4:0]  OFF_SENSE    = 5'h04;
   localparam logic [4:0]  OFF_ENABLE   = 5'h08;
   localparam logic [4:0]  OFF_STATUS   = 5'h0C;
   localparam logic [4:0]  OFF_LVL_EXT  = 5'h10;
   localparam logic [4:0]  OFF_LVL_INT0 = 5'h14;
   localparam logic [4:0]  OFF_LVL_INT1 = 5'h18;
   // field positions
   localparam int          SYS_NMI_EDGE = 0;
   localparam int          SENSE_A      = 0;
   localparam int          SENSE_B      = 1;
   localparam int          LVL_INT_HI_W = INT_SRC - DATA_W;
   // sense modes, {b, a}
   localparam logic [1:0]  MODE_LOW     = 2'h0;
   localparam logic [1:0]  MODE_FALL    = 2'h1;
   localparam logic [1:0]  MODE_RISE    = 2'h2;
   localparam logic [1:0]  MODE_BOTH    = 2'h3;
   // exception vectors
   localparam logic [5:0]  VEC_NMI      = 6'h07;
   localparam logic [5:0]  VEC_EXT_BASE = 6'h10;
   localparam logic [5:0]  VEC_EXT_TOP  = 6'h17;
   // channels that may leave software standby
   localparam logic [7:0]  WAKE_MASK    = 8'h07;
   // control level bit used by each channel, channel 0 first
   localparam logic [2:0]  CH_LVL_IDX [EXT_CH] = '{3'h7, 3'h6, 3'h5, 3'h5,
                                                   3'h4, 3'h4, 3'h3, 3'h3};
   localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : irq_front_pkg

// ==== sim/irq_cpu_model.sv ====
// cpu side model that takes exception handling for pending requests
`timescale 1ns/1ps
module irq_cpu_model (
   input  wire logic                             i_ref_clk,
   input  wire logic                             i_rst_n,
   input  wire logic                             i_ack_en,
   input  wire logic [3:0]                       i_ack_delay,
   input  wire logic                             i_nmi_req,
   input  wire logic [irq_front_pkg::EXT_CH-1:0] i_ext_req,
   output logic                                  o_ack_valid,
   output logic      [irq_front_pkg::VEC_W-1:0]  o_ack_vector
);
   import irq_front_pkg::*;
   logic [4:0] wait_r;
   logic [2:0] pick;
   // lowest pending channel has the lowest vector, so it goes first
   always_comb begin
      pick = 3'h0;
      for (int i = EXT_CH - 1; i >= 0; i--) begin
         if (i_ext_req[i]) begin
            pick = 3'(i);
         end
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         wait_r       <= 5'h00;
         o_ack_valid  <= 1'b0;
         o_ack_vector <= 6'h00;
      end else if (!i_ack_en || !(i_nmi_req || |i_ext_req)) begin
         wait_r      <= 5'h00;
         o_ack_valid <= 1'b0;
      end else if (wait_r < 5'(i_ack_delay) + 5'h03) begin
         wait_r      <= wait_r + 5'h01;
         o_ack_valid <= 1'b0;
      end else begin
         // non-maskable first, channel n on vector 16+n
         wait_r       <= 5'h00;
         o_ack_valid  <= 1'b1;
         o_ack_vector <= i_nmi_req ? 6'h07 : 6'h10 + 6'(pick);
      end
   end
endmodule : irq_cpu_model

// ==== sim/irq_front_bench.sv ====
// self-checking bench for the external interrupt request front end
`timescale 1ns/1ps
module irq_front_bench;
   import irq_front_pkg::*;
   logic                ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, nmi_pin;
   logic                ack_valid, xfer_start, xfer_int_select, nmi_req, wake, ack_en;
   logic [ADDR_W-1:0]   avs_address;
   logic [DATA_W-1:0]   avs_writedata, avs_readdata;
   logic [EXT_CH-1:0]   ext_pin, ext_req, ext_level, xfer_req;
   logic [INT_SRC-1:0]  int_flag, int_enable, int_req, int_level;
   logic [VEC_W-1:0]    ack_vector;
   logic [CH_W-1:0]     xfer_channel;
   logic [3:0]          ack_delay;
   int                  fails, checks_done;
   irq_front u_dut (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest), .i_nmi_pin(nmi_pin),
      .i_ext_request_pin(ext_pin), .i_int_flag(int_flag), .i_int_enable(int_enable),
      .i_ack_valid(ack_valid), .i_ack_vector(ack_vector), .i_xfer_start(xfer_start),
      .i_xfer_channel(xfer_channel), .i_xfer_int_select(xfer_int_select),
      .o_nmi_req(nmi_req), .o_ext_req(ext_req), .o_ext_level(ext_level),
      .o_xfer_req(xfer_req), .o_int_req(int_req), .o_int_level(int_level), .o_wake(wake));
   irq_cpu_model u_cpu (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ack_en(ack_en), .i_ack_delay(ack_delay),
      .i_nmi_req(nmi_req), .i_ext_req(ext_req), .o_ack_valid(ack_valid),
      .o_ack_vector(ack_vector));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic complete_run;
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one avalon access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 40) begin
         chk("waitrequest", 64'h0, 64'(avs_waitrequest));
         complete_run();
      end
   endtask : bus
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr
   task automatic rdc(input string what, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(what, 64'(exp), 64'(d));
   endtask : rdc
   // sel 0: ext_req[b], 1: nmi_req, 2: xfer_req[b]
   task automatic wait_sig(input int sel, input int b, input logic exp);
      int   n;
      logic v;
      n = 0;
      v = ~exp;
      while (v !== exp) begin
         @(posedge ref_clk);
         n++;
         v = (sel == 0) ? ext_req[b] : (sel == 1) ? nmi_req : xfer_req[b];
         if (n > 40) begin
            chk("request wait", 64'(exp), 64'(v));
            complete_run();
         end
      end
   endtask : wait_sig
   task automatic t_regs;
      for (int a = 0; a < 32; a += 4) begin
         rdc("reset value", 5'(a), 32'h0);
      end
      wr(OFF_SENSE, 32'h0000_A55A);
      rdc("sense reg", OFF_SENSE, 32'h0000_A55A);
      wr(5'h1C, 32'hFFFF_FFFF);
      rdc("unmapped", 5'h1C, 32'h0);
      wr(OFF_STATUS, 32'h0000_00FF);
      rdc("status write one", OFF_STATUS, 32'h0);
      wr(OFF_SENSE, 32'h0);
   endtask : t_regs
   task automatic t_sense;
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(OFF_SENSE, 32'(m) << 6);
         wr(OFF_STATUS, 32'h0);
         ext_pin[3] <= 1'b0;
         repeat (6) @(posedge ref_clk);
         rdc("flag on low", OFF_STATUS, (m != MODE_RISE) ? 32'h08 : 32'h0);
         ext_pin[3] <= 1'b1;
         repeat (6) @(posedge ref_clk);
         rdc("flag on high", OFF_STATUS, 32'h08);
         chk("masked request", 64'h0, 64'(ext_req));
         wr(OFF_STATUS, 32'h0);
         rdc("flag cleared", OFF_STATUS, 32'h0);
      end
   endtask : t_sense
   task automatic t_ack;
      wr(OFF_LVL_EXT, 32'h0000_00A8);
      wr(OFF_SENSE, 32'h0000_5555);
      wr(OFF_ENABLE, 32'h0000_00FF);
      chk("ext level", 64'hCD, 64'(ext_level));
      ack_en <= 1'b1;
      for (int ch = 0; ch < 8; ch++) begin
         ack_delay <= ch[0] ? 4'h4 : 4'h0;
         ext_pin[ch] <= 1'b0;
         wait_sig(0, ch, 1'b1);
         chk("wake", 64'(ch < 3), 64'(wake));
         wait_sig(0, ch, 1'b0);
         rdc("flag after ack", OFF_STATUS, 32'h0);
         chk("wake after ack", 64'h0, 64'(wake));
         ext_pin[ch] <= 1'b1;
         @(posedge ref_clk);
      end
      wr(OFF_ENABLE, 32'h0);
   endtask : t_ack
   task automatic t_nmi;
      nmi_pin <= 1'b0;
      wait_sig(1, 0, 1'b1);
      wait_sig(1, 0, 1'b0);
      nmi_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("nmi rise, fall select", 64'h0, 64'(nmi_req));
      wr(OFF_SYS, 32'h1);
      nmi_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("nmi fall, rise select", 64'h0, 64'(nmi_req));
      nmi_pin <= 1'b1;
      wait_sig(1, 0, 1'b1);
      wait_sig(1, 0, 1'b0);
      ack_en <= 1'b0;
   endtask : t_nmi
   task automatic t_xfer(input logic sel_bit, input logic exp);
      xfer_channel    <= 3'h5;
      xfer_int_select <= sel_bit;
      xfer_start      <= 1'b1;
      @(posedge ref_clk);
      xfer_start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("xfer request", 64'(exp), 64'(xfer_req[5]));
   endtask : t_xfer
   initial begin
      {rst_n, avs_read, avs_write, xfer_start, xfer_int_select, ack_en} = '0;
      {avs_address, avs_writedata, int_flag, int_enable, xfer_channel, ack_delay} = '0;
      {fails, checks_done} = '0;
      nmi_pin = 1'b1;
      // request pins are used as inputs only
      ext_pin = 8'hFF;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_sense();
      t_ack();
      t_nmi();
      wr(OFF_SENSE, 32'h0000_0400);
      wr(OFF_ENABLE, 32'h0000_0020);
      ext_pin[5] <= 1'b0;
      wait_sig(2, 5, 1'b1);
      t_xfer(1'b1, 1'b1);
      t_xfer(1'b0, 1'b0);
      rdc("flag after xfer", OFF_STATUS, 32'h0);
      ext_pin[5] <= 1'b1;
      int_flag   <= 34'h2_F0F0_1234;
      int_enable <= 34'h3_00FF_FF00;
      repeat (2) @(posedge ref_clk);
      chk("int req", 64'h2_00F0_1200, 64'(int_req));
      wr(OFF_LVL_INT0, 32'hA5A5_5A5A);
      wr(OFF_LVL_INT1, 32'h0000_0002);
      rdc("int level hi", OFF_LVL_INT1, 32'h0000_0002);
      chk("int level", 64'h2_A5A5_5A5A, 64'(int_level));
      complete_run();
   end
endmodule : irq_front_bench
